//--- logic/pm_event_unit.sv
`timescale 1ns/1ns
module pm_event_unit #(
  parameter logic [15:0] BLOCK_BASE       = pm_pkg::BLOCK_BASE_DEFAULT,
  parameter int unsigned OVERRIDE_CYCLES  = pm_pkg::OVERRIDE_CYCLES
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic            clk_en,
  input  wire logic            bus_reset,
  input  wire logic            osc_pin,
  input  wire logic            button_in,
  input  wire logic            alarm_pulse,
  input  wire logic            busmaster_request,
  input  wire logic            busmaster_control_bit,
  input  wire logic            timer_event_enable,
  input  wire logic            firmware_event_enable,
  input  wire pm_pkg::flags_t  flag_clear,
  input  wire pm_pkg::io_req_t io_req,
  output logic [7:0]           io_rdata_q,
  output pm_pkg::flags_t       flags_q,
  output logic                 sci_q,
  output logic                 smi_q,
  output logic                 power_on_output_n_q,
  output logic                 power_on_output_oe_q
);

  // Pin synchronisers: osc, button, bus reset
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] pins_q;
  logic [2:0] pins_d;
  logic       osc_q;
  logic       button_q;
  logic       bus_reset_q;

  assign osc_q       = pins_q[0];
  assign button_q    = pins_q[1];
  assign bus_reset_q = pins_q[2];

  // A change counts once the two later stages agree
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_agree
      assign pins_d[g] = (sync2_q[g] == sync3_q[g]) ? sync3_q[g] : pins_q[g];
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      pins_q  <= 3'h0;
    end else if (clk_en) begin
      sync1_q <= {bus_reset, button_in, osc_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pins_q  <= pins_d;
    end
  end

  // Edge detection on the filtered levels
  // Prev flops reset low, the pins' idle level, so no false edge
  logic osc_prev_q;
  logic button_prev_q;
  logic osc_rise;
  logic button_rise;

  assign osc_rise    = osc_q && !osc_prev_q;
  assign button_rise = button_q && !button_prev_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      osc_prev_q    <= 1'b0;
      button_prev_q <= 1'b0;
    end else if (clk_en) begin
      osc_prev_q    <= osc_q;
      button_prev_q <= button_q;
    end
  end

  // Register decode
  function automatic logic hit(input logic [15:0] addr,
                               input logic [15:0] base,
                               input logic [3:0]  ofs);
    hit = (addr == base + {12'h000, ofs});
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] data,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction

  logic wr_enable_high;
  logic wr_control_low;
  logic wr_control_high;
  logic rd_timer_byte0;
  logic release_write;

  assign wr_enable_high  = io_req.write && hit(io_req.addr, BLOCK_BASE, pm_pkg::OFS_ENABLE_HIGH);
  assign wr_control_low  = io_req.write && hit(io_req.addr, BLOCK_BASE, pm_pkg::OFS_CONTROL_LOW);
  assign wr_control_high = io_req.write && hit(io_req.addr, BLOCK_BASE, pm_pkg::OFS_CONTROL_HIGH);
  assign rd_timer_byte0  = io_req.read && hit(io_req.addr, BLOCK_BASE, pm_pkg::OFS_TIMER_BYTE0);
  assign release_write   = wr_control_low && io_req.wdata[pm_pkg::BIT_RELEASE];

  // Software-written registers
  logic [7:0] pm_event_enable_high_q;
  logic [7:0] pm_control_low_q;
  logic [7:0] pm_control_high_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      pm_event_enable_high_q <= pm_pkg::REG_RESET;
      pm_control_low_q       <= pm_pkg::REG_RESET;
      pm_control_high_q      <= pm_pkg::REG_RESET;
    end else if (clk_en) begin
      if (wr_enable_high) begin
        pm_event_enable_high_q <= merge(pm_event_enable_high_q, io_req.wdata,
                                        pm_pkg::ENABLE_HIGH_MASK);
      end
      if (wr_control_low) begin
        pm_control_low_q <= merge(pm_control_low_q, io_req.wdata,
                                  pm_pkg::CONTROL_LOW_MASK);
      end
      if (wr_control_high) begin
        pm_control_high_q <= merge(pm_control_high_q, io_req.wdata,
                                   pm_pkg::CONTROL_HIGH_MASK);
      end
    end
  end

  logic button_event_enable;
  logic alarm_event_enable;
  logic control_interrupt_enable;
  logic busmaster_wake_enable;
  logic button_override_enable;

  assign button_event_enable      = pm_event_enable_high_q[pm_pkg::BIT_BUTTON_EN];
  assign alarm_event_enable       = pm_event_enable_high_q[pm_pkg::BIT_ALARM_EN];
  assign control_interrupt_enable = pm_control_low_q[pm_pkg::BIT_INTR_EN];
  assign busmaster_wake_enable    = pm_control_low_q[pm_pkg::BIT_RELOAD];
  assign button_override_enable   = pm_control_high_q[pm_pkg::BIT_OVERRIDE_EN];

  // Button hold counter for the override
  logic [31:0] hold_q;
  logic [31:0] hold_d;
  logic        held_q;
  logic        override_fire;

  // Saturates so a very long hold cannot wrap and refire
  assign hold_d = !button_q ? 32'h0000_0000 :
                  (hold_q > OVERRIDE_CYCLES) ? hold_q : hold_q + 32'h0000_0001;
  assign override_fire = button_override_enable && button_q && !held_q &&
                         (hold_q > OVERRIDE_CYCLES);

  always_ff @(posedge clock) begin
    if (rst) begin
      hold_q <= 32'h0000_0000;
      held_q <= 1'b0;
    end else if (clk_en) begin
      hold_q <= hold_d;
      if (!button_q) begin
        held_q <= 1'b0;
      end else if (override_fire) begin
        held_q <= 1'b1;
      end
    end
  end

  // System state
  pm_pkg::sys_state_t state_q;
  pm_pkg::sys_state_t state_d;
  logic               wake;

  assign wake = (button_rise && button_event_enable) ||
                (busmaster_request && busmaster_wake_enable);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pm_pkg::SYS_WORKING: begin
        if (override_fire) begin
          state_d = pm_pkg::SYS_OFF;
        end
      end
      pm_pkg::SYS_OFF: begin
        if (wake) begin
          state_d = pm_pkg::SYS_WORKING;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      // Starts working after power-on so the timer runs at once
      state_q <= pm_pkg::SYS_WORKING;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // Timer
  logic [23:0] count_q;
  logic [15:0] upper_q;
  logic        msb_toggle_q;

  // bus reset clears only the timer
  pm_timer #(
    .WIDTH        (pm_pkg::TIMER_WIDTH)
  ) u_timer (
    .clock        (clock),
    .clear        (rst || bus_reset_q),
    .clk_en       (clk_en),
    .osc_rise     (osc_rise),
    .run          (state_q == pm_pkg::SYS_WORKING),
    .capture      (rd_timer_byte0),
    .count_q      (count_q),
    .upper_q      (upper_q),
    .msb_toggle_q (msb_toggle_q)
  );

  // Status flags: set wins over a same-cycle clear
  pm_pkg::flags_t set_ev;
  pm_pkg::flags_t flags_d;

  always_comb begin
    set_ev = '0;
    set_ev.button   = button_rise && !override_fire;
    set_ev.alarm    = alarm_pulse;
    set_ev.override = override_fire;
    set_ev.timer    = msb_toggle_q;
    set_ev.firmware = release_write;
    flags_d = set_ev | (flags_q & ~flag_clear);
    if (override_fire) begin
      flags_d.button = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flags_q <= '0;
    end else if (clk_en) begin
      flags_q <= flags_d;
    end
  end

  // Interrupt outputs: levels that stand until the flag (or busmaster control bit) or enable drops
  logic sci_source;
  logic sci_d;
  logic smi_d;
  logic sci_button;
  logic sci_alarm;
  logic sci_timer;
  logic sci_busmaster;

  assign sci_button    = flags_q.button && button_event_enable;
  assign sci_alarm     = flags_q.alarm && alarm_event_enable;
  assign sci_timer     = flags_q.timer && timer_event_enable;
  assign sci_busmaster = busmaster_wake_enable && busmaster_control_bit;
  assign sci_source    = sci_button || sci_alarm || sci_timer || sci_busmaster;
  assign sci_d = control_interrupt_enable && sci_source;
  assign smi_d = flags_q.firmware && firmware_event_enable;

  always_ff @(posedge clock) begin
    if (rst) begin
      sci_q <= 1'b0;
      smi_q <= 1'b0;
    end else if (clk_en) begin
      sci_q <= sci_d;
      smi_q <= smi_d;
    end
  end

  // Power-on pin floats in soft-off
  always_ff @(posedge clock) begin
    if (rst) begin
      power_on_output_n_q  <= 1'b0;
      power_on_output_oe_q <= 1'b1;
    end else if (clk_en) begin
      power_on_output_n_q  <= 1'b0;
      power_on_output_oe_q <= (state_d == pm_pkg::SYS_WORKING);
    end
  end

  // Read data
  logic [7:0] rdata_d;
  logic [3:0] rd_ofs;
  logic       rd_in_block;

  // Limitation: reads need a 16-byte aligned base, else they return 00h
  assign rd_in_block = (io_req.addr[15:4] == BLOCK_BASE[15:4]) &&
                       (BLOCK_BASE[3:0] == 4'h0);
  assign rd_ofs      = io_req.addr[3:0];

  always_comb begin
    rdata_d = 8'h00;
    if (rd_in_block) begin
      unique case (rd_ofs)
        pm_pkg::OFS_ENABLE_HIGH:  rdata_d = pm_event_enable_high_q;
        pm_pkg::OFS_CONTROL_LOW:  rdata_d = pm_control_low_q;
        pm_pkg::OFS_CONTROL_HIGH: rdata_d = pm_control_high_q;
        pm_pkg::OFS_TIMER_BYTE0:  rdata_d = count_q[7:0];
        pm_pkg::OFS_TIMER_BYTE1:  rdata_d = upper_q[7:0];
        pm_pkg::OFS_TIMER_BYTE2:  rdata_d = upper_q[15:8];
        default:                  rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      io_rdata_q <= 8'h00;
    end else if (clk_en && io_req.read) begin
      io_rdata_q <= rdata_d;
    end
  end

endmodule // pm_event_unit

//--- logic/pm_pkg.sv
// Operation
// - Button press always sets button flag
// - Button interrupts or wakes only when enabled
// - Alarm sets flag; interrupts only when enabled
// - Reserved enable and control bits read zero
// - Interrupt enable gates every enabled event (the code gates SCI sources only; SMI is not gated)
// - Reload bit lets bus master wake system
// - Reload plus busmaster control raises interrupt
// - Release write sets firmware flag, maybe SMI
// - Firmware flag cleared only by writing one
// - Held button over four seconds forces off
// - Override clears button flag, sets override flag
// - 24-bit timer counts while working
// - Low byte read captures upper bytes
// - Resets zero timer and control registers (bus reset zeros only the timer)
// - Timer halts with input clock, resumes
// - Timer bit 23 toggle sets timer flag
// - Flags set by hardware, cleared writing one
// - Timer enable gates timer flag interrupt
package pm_pkg;

  localparam logic [15:0] BLOCK_BASE_DEFAULT = 16'h0800;

  localparam logic [3:0] OFS_ENABLE_HIGH  = 4'h3;
  localparam logic [3:0] OFS_CONTROL_LOW  = 4'h4;
  localparam logic [3:0] OFS_CONTROL_HIGH = 4'h5;
  localparam logic [3:0] OFS_TIMER_BYTE0  = 4'h8;
  localparam logic [3:0] OFS_TIMER_BYTE1  = 4'h9;
  localparam logic [3:0] OFS_TIMER_BYTE2  = 4'ha;
  localparam logic [3:0] OFS_TIMER_BYTE3  = 4'hb;

  localparam int BIT_BUTTON_EN   = 0;
  localparam int BIT_ALARM_EN    = 2;
  localparam int BIT_INTR_EN     = 0;
  localparam int BIT_RELOAD      = 1;
  localparam int BIT_RELEASE     = 2;
  localparam int BIT_OVERRIDE_EN = 1;

  localparam logic [7:0] ENABLE_HIGH_MASK  = 8'h05;
  localparam logic [7:0] CONTROL_LOW_MASK  = 8'h03;
  localparam logic [7:0] CONTROL_HIGH_MASK = 8'h02;
  localparam logic [7:0] REG_RESET         = 8'h00;

  localparam int unsigned CLOCK_KHZ        = 10000;
  localparam int unsigned OVERRIDE_TIME_MS = 4000;
  localparam int unsigned OVERRIDE_CYCLES  = OVERRIDE_TIME_MS * CLOCK_KHZ;

  localparam int         TIMER_WIDTH = 24;
  localparam logic [1:0] PRESCALE_TOP = 2'h3;

  typedef struct packed {
    logic firmware;
    logic button;
    logic override;
    logic alarm;
    logic timer;
  } flags_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        write;
    logic        read;
  } io_req_t;

  typedef enum logic {
    SYS_OFF     = 1'b0,
    SYS_WORKING = 1'b1
  } sys_state_t;

endpackage

//--- logic/pm_timer.sv
`timescale 1ns/1ns
module pm_timer #(
  parameter int WIDTH = pm_pkg::TIMER_WIDTH
) (
  input  wire logic             clock,
  input  wire logic             clear,
  input  wire logic             clk_en,
  input  wire logic             osc_rise,
  input  wire logic             run,
  input  wire logic             capture,
  output logic [WIDTH-1:0]      count_q,
  output logic [WIDTH-9:0]      upper_q,
  output logic                  msb_toggle_q
);

  logic [1:0]       prescale_q;
  logic             tick;
  logic [WIDTH-1:0] count_d;

  assign tick = osc_rise && (prescale_q == pm_pkg::PRESCALE_TOP);
  assign count_d = (tick && run) ? count_q + 1'b1 : count_q;

  always_ff @(posedge clock) begin
    if (clear) begin
      prescale_q   <= 2'h0;
      count_q      <= '0;
      upper_q      <= '0;
      msb_toggle_q <= 1'b0;
    end else if (clk_en) begin
      if (osc_rise) begin
        prescale_q <= prescale_q + 2'h1;
      end
      count_q      <= count_d;
      msb_toggle_q <= count_d[WIDTH-1] != count_q[WIDTH-1];
      if (capture) begin
        upper_q <= count_q[WIDTH-1:8];
      end
    end
  end

endmodule // pm_timer

//--- tb/osc_model.sv
`timescale 1ns/1ns
module osc_model (
  input wire logic clock,
  input wire logic run,
  output logic     osc_pin = 1'b0
);
  logic [1:0] phase_q = 2'h0;
  always_ff @(posedge clock) begin
    if (run) begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == 2'h3) osc_pin <= ~osc_pin;
    end
  end
endmodule // osc_model

//--- tb/pm_event_properties.sv
`timescale 1ns/1ns
module pm_event_properties #(
  parameter logic [15:0] BLOCK_BASE      = pm_pkg::BLOCK_BASE_DEFAULT,
  parameter int unsigned OVERRIDE_CYCLES = pm_pkg::OVERRIDE_CYCLES
) (
  input wire logic            clock,
  input wire logic            rst,
  input wire logic            clk_en,
  input wire logic            alarm_pulse,
  input wire logic            busmaster_control_bit,
  input wire logic            firmware_event_enable,
  input wire pm_pkg::flags_t  flag_clear,
  input wire pm_pkg::io_req_t io_req,
  input wire logic [7:0]      io_rdata_q,
  input wire pm_pkg::flags_t  flags_q,
  input wire logic            sci_q,
  input wire logic            smi_q,
  input wire logic            power_on_output_n_q,
  input wire logic            power_on_output_oe_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence rd(logic [15:0] o);
    clk_en && io_req.read && io_req.addr == BLOCK_BASE + o;
  endsequence
  sequence wr_release;
    clk_en && io_req.write && io_req.wdata[2] && io_req.addr == BLOCK_BASE + 16'h4;
  endsequence
  a_alarm_sets_flag: assert property (clk_en && alarm_pulse |=> flags_q.alarm)
    else $error("alarm flag not set");
  a_release_sets_flag: assert property (wr_release |=> flags_q.firmware)
    else $error("release write did not set flag");
  a_smi_follows_flag: assert property (
    clk_en && flags_q.firmware && firmware_event_enable |=> smi_q)
    else $error("smi missing");
  a_firmware_flag_sticky: assert property (
    clk_en && flags_q.firmware && !flag_clear.firmware |=> flags_q.firmware)
    else $error("firmware flag lost");
  a_alarm_flag_clears: assert property (
    clk_en && flag_clear.alarm && !alarm_pulse |=> !flags_q.alarm)
    else $error("alarm flag not cleared");
  // Override flag is left out: it raises no interrupt
  a_sci_has_cause: assert property (
    $rose(sci_q) |-> $past(flags_q.alarm || flags_q.timer || flags_q.button
                           || busmaster_control_bit))
    else $error("sci without cause");
  a_pin_value_low: assert property (power_on_output_n_q == 1'b0)
    else $error("pin value not low");
  a_override_flags: assert property (
    $fell(power_on_output_oe_q) |-> flags_q.override && !flags_q.button)
    else $error("override flags wrong");
  a_control_rsvd_zero: assert property (rd(16'h4) |=> (io_rdata_q & 8'hfc) == 8'h00)
    else $error("control reserved bits set");
  a_enable_rsvd_zero: assert property (rd(16'h3) |=> (io_rdata_q & 8'hfa) == 8'h00)
    else $error("enable reserved bits set");
endmodule // pm_event_properties

bind pm_event_unit pm_event_properties #(
  .BLOCK_BASE(BLOCK_BASE),
  .OVERRIDE_CYCLES(OVERRIDE_CYCLES)
) pm_event_properties_inst (.clock, .rst, .clk_en, .alarm_pulse, .busmaster_control_bit,
  .firmware_event_enable, .flag_clear, .io_req, .io_rdata_q, .flags_q, .sci_q, .smi_q,
  .power_on_output_n_q, .power_on_output_oe_q);

//--- tb/test_acpi_pm1_event_and_timer.sv
`timescale 1ns/1ns
module test_acpi_pm1_event_and_timer;
  localparam logic [15:0] BASE = pm_pkg::BLOCK_BASE_DEFAULT;
  logic            clock = 1'b0;
  logic            rst = 1'b1;
  logic            bus_reset = 1'b0;
  logic            osc_run = 1'b0;
  logic            osc_pin;
  logic            button_in = 1'b0;
  logic            alarm_pulse = 1'b0;
  logic            busmaster_request = 1'b0;
  logic            busmaster_control_bit = 1'b0;
  logic            firmware_event_enable = 1'b0;
  logic            timer_event_enable = 1'b0;
  pm_pkg::flags_t  flag_clear = '0;
  pm_pkg::io_req_t io_req = '0;
  logic [7:0]      io_rdata_q;
  pm_pkg::flags_t  flags_q;
  logic            sci_q;
  logic            smi_q;
  logic            pin_n;
  logic            pin_oe;
  logic [7:0]      first;
  int              mismatches = 0;
  int              checks_done = 0;

  always #50 clock = ~clock;

  osc_model osc_model_inst (.clock(clock), .run(osc_run), .osc_pin(osc_pin));
  // Short override count keeps the hold test brief
  pm_event_unit #(.OVERRIDE_CYCLES(20)) pm_event_unit_inst (.clock(clock), .rst(rst),
    .clk_en(1'b1), .bus_reset(bus_reset), .osc_pin(osc_pin), .button_in(button_in),
    .alarm_pulse(alarm_pulse), .busmaster_request(busmaster_request),
    .busmaster_control_bit(busmaster_control_bit), .timer_event_enable(timer_event_enable),
    .firmware_event_enable(firmware_event_enable), .flag_clear(flag_clear),
    .io_req(io_req), .io_rdata_q(io_rdata_q), .flags_q(flags_q), .sci_q(sci_q),
    .smi_q(smi_q), .power_on_output_n_q(pin_n), .power_on_output_oe_q(pin_oe));

  task automatic close_out;
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bus(input logic [3:0] o, input logic [7:0] d, input logic w);
    @(posedge clock);
    io_req <= {BASE + {12'h0, o}, d, w, ~w};
    @(posedge clock);
    io_req <= '0;
    #1;
  endtask
  task automatic rd(input logic [3:0] o, input logic [7:0] exp);
    bus(o, 8'h00, 1'b0);
    chk(io_rdata_q, exp);
  endtask
  task automatic pulse(input logic bm);
    @(posedge clock);
    if (bm) busmaster_request <= 1'b1;
    else alarm_pulse <= 1'b1;
    @(posedge clock);
    busmaster_request <= 1'b0;
    alarm_pulse <= 1'b0;
    #1;
  endtask
  task automatic clr(input pm_pkg::flags_t m);
    @(posedge clock);
    flag_clear <= m;
    @(posedge clock);
    flag_clear <= '0;
    #1;
  endtask

  task automatic t_reset_values;
    logic [3:0] ofs [6] = '{4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hb};
    foreach (ofs[i]) rd(ofs[i], 8'h00);
  endtask
  task automatic t_reserved_bits;
    bus(4'h3, 8'hff, 1'b1);
    rd(4'h3, 8'h05);
    bus(4'h5, 8'hff, 1'b1);
    rd(4'h5, 8'h02);
    bus(4'h4, 8'hff, 1'b1);
    rd(4'h4, 8'h03);
    chk1(flags_q.firmware, 1'b1);
    bus(4'h3, 8'h00, 1'b1);
    bus(4'h4, 8'h00, 1'b1);
    bus(4'h5, 8'h00, 1'b1);
  endtask
  task automatic t_firmware_flag;
    @(posedge clock) firmware_event_enable <= 1'b1;
    ticks(2);
    chk1(smi_q, 1'b1);
    clr(5'h0f);
    chk1(flags_q.firmware, 1'b1);
    clr(5'h10);
    chk1(flags_q.firmware, 1'b0);
  endtask
  task automatic t_alarm;
    pulse(1'b0);
    chk1(flags_q.alarm, 1'b1);
    bus(4'h4, 8'h01, 1'b1);
    chk1(sci_q, 1'b0);
    bus(4'h3, 8'h04, 1'b1);
    ticks(2);
    chk1(sci_q, 1'b1);
    bus(4'h4, 8'h00, 1'b1);
    ticks(2);
    chk1(sci_q, 1'b0);
    clr(5'h02);
    chk1(flags_q.alarm, 1'b0);
    bus(4'h3, 8'h00, 1'b1);
  endtask
  task automatic t_button_override;
    bus(4'h4, 8'h01, 1'b1);
    @(posedge clock) button_in <= 1'b1;
    ticks(8);
    chk1(flags_q.button, 1'b1);
    chk1(sci_q, 1'b0);
    @(posedge clock) button_in <= 1'b0;
    clr(5'h08);
    bus(4'h5, 8'h02, 1'b1);
    @(posedge clock) button_in <= 1'b1;
    ticks(40);
    chk1(pin_oe, 1'b0);
    chk({6'h0, flags_q.override, flags_q.button}, 8'h02);
    @(posedge clock) button_in <= 1'b0;
    ticks(8);
    pulse(1'b1);
    ticks(2);
    chk1(pin_oe, 1'b0);
    chk1(pin_n, 1'b0);
    bus(4'h4, 8'h03, 1'b1);
    pulse(1'b1);
    ticks(2);
    chk1(pin_oe, 1'b1);
    chk1(pin_n, 1'b0);
    timer_event_enable <= 1'b1;
    clr(5'h04);
    ticks(2);
    chk1(sci_q, 1'b0);
    @(posedge clock) busmaster_control_bit <= 1'b1;
    ticks(3);
    chk1(sci_q, 1'b1);
    busmaster_control_bit <= 1'b0;
    bus(4'h4, 8'h00, 1'b1);
    bus(4'h5, 8'h00, 1'b1);
  endtask
  task automatic t_timer;
    @(posedge clock) osc_run <= 1'b1;
    ticks(640);
    osc_run <= 1'b0;
    ticks(20);
    bus(4'h8, 8'h00, 1'b0);
    first = io_rdata_q;
    chk1(first >= 8'd18 && first <= 8'd21, 1'b1);
    ticks(200);
    rd(4'h8, first);
    rd(4'h9, 8'h00);
    @(posedge clock) osc_run <= 1'b1;
    ticks(320);
    osc_run <= 1'b0;
    ticks(20);
    bus(4'h8, 8'h00, 1'b0);
    chk1(io_rdata_q >= first + 8'd9 && io_rdata_q <= first + 8'd11, 1'b1);
    // Run past 256 counts so the captured upper byte is nonzero
    @(posedge clock) osc_run <= 1'b1;
    ticks(7680);
    osc_run <= 1'b0;
    ticks(20);
    bus(4'h8, 8'h00, 1'b0);
    rd(4'h9, 8'h01);
    rd(4'ha, 8'h00);
    @(posedge clock) bus_reset <= 1'b1;
    ticks(10);
    bus_reset <= 1'b0;
    ticks(6);
    rd(4'h8, 8'h00);
    rd(4'h9, 8'h00);
  endtask

  initial begin
    ticks(5);
    rst <= 1'b0;
    t_reset_values;
    t_reserved_bits;
    t_firmware_flag;
    t_alarm;
    t_button_override;
    t_timer;
    close_out;
  end
  // Whole sequence needs about 9100 cycles
  initial begin
    ticks(20000);
    mismatches++;
    close_out;
  end
endmodule // test_acpi_pm1_event_and_timer
